// *** bfg_top.sv ***
// Sequencer for a 32-bit processor bus in front of synchronous burst flash.
// Assumes processor inputs are synchronous to clk_sys_in; external latches
// and the low-address multiplexer sit outside and follow our strobes.
`timescale 1ns/1ns
`default_nettype none
`include "bfg_defs.svh"
// Behaviour
// - Counter loads address bits 3:2 first clock
// - Write strobe launched on second falling edge
// - Write strobe held two full periods
// - Single write holds until last, then idle
// - Profile select low: single writes only
// - Burst: counter increments, next strobe follows
// - Burst writes continue until last transfer
// - Counter and select settle before strobe
// - Drive address hold strobe for latches
// - Upper address latched, low from counter
// - Counter loaded then incremented each beat
// - First read access uses processor low bits
// - Sequencer drives enables, valid and ready
// - One reset for all, drives flash powerdown
// - Read waits 4-1-1-1 then 2-0-0-0
// - Bursts usable straight after reset
// - Flash takes address when valid strobe low
// - Flash takes data on strobe rising edge
// - Select held until last without strobe
module bfg_top (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Processor bus
  input wire bfg_pkg::bfg_cpu_t cpu_in,
  input wire logic profile_sel_in,
  // Processor write data
  input wire logic wdata_valid_in,
  input wire logic [31:0] wdata_in,
  output logic wdata_ready_out,
  // Flash control and data
  output bfg_pkg::bfg_ctl_t ctl_out,
  output logic flash_we_n_out,
  output logic [1:0] burst_count_out,
  output logic [31:0] flash_wdata_out
);
  bfg_pkg::bfg_state_t state_r;
  bfg_pkg::bfg_state_t state_nxt;
  logic [2:0] wait_r;
  logic [2:0] wait_nxt;
  logic [1:0] we_cnt_r;
  logic start;
  logic hit;
  logic cnt_load;
  logic cnt_inc;
  logic [1:0] cnt_load_val;
  logic fifo_valid;
  logic fifo_pop;
  logic [31:0] fifo_data;
  logic [2:0] first_waits;
  logic [2:0] next_waits;

  // Flash space decode; other transactions pass untouched
  assign hit = cpu_in.addr[`BFG_TAG_LSB +: `BFG_TAG_W] == `BFG_FLASH_TAG;
  assign start = !cpu_in.addr_strobe_n && hit;

  // Wait profile chosen by the select input; low means boot profile
  assign first_waits = profile_sel_in ? `BFG_RD_FIRST_OPT : `BFG_RD_FIRST_BOOT;
  assign next_waits = profile_sel_in ? `BFG_RD_NEXT_OPT : `BFG_RD_NEXT_BOOT;

  // Writes pop one word as each strobe is about to start
  assign fifo_pop = (state_nxt == bfg_pkg::st_wpulse) && (state_r != bfg_pkg::st_wpulse);

  bfg_fifo #(
    .WIDTH(`BFG_FIFO_W),
    .DEPTH(`BFG_FIFO_D)
  ) u_fifo (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .in_valid_in(wdata_valid_in),
    .in_data_in(wdata_in),
    .in_ready_out(wdata_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(fifo_pop)
  );

  bfg_counter u_cnt (
    .clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in),
    .load_in(cnt_load),
    .inc_in(cnt_inc),
    .load_val_in(cnt_load_val),
    .count_out(burst_count_out)
  );

  // Next state, counter control and wait count
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    cnt_load = 1'b0;
    cnt_inc = 1'b0;
    cnt_load_val = cpu_in.addr[`BFG_CNT_LSB +: `BFG_CNT_W];
    case (state_r)
      bfg_pkg::st_idle: begin
        if (start && cpu_in.wr) begin
          cnt_load = 1'b1;
          state_nxt = bfg_pkg::st_wload;
        end else if (start) begin
          // Processor already drove the first address, so skip past it
          cnt_load = 1'b1;
          cnt_load_val = cpu_in.addr[`BFG_CNT_LSB +: `BFG_CNT_W] + 2'h1;
          wait_nxt = first_waits;
          state_nxt = (first_waits == 3'h0) ? bfg_pkg::st_rbeat : bfg_pkg::st_rwait;
        end
      end
      bfg_pkg::st_wload: begin
        // Data must be in the FIFO before the strobe can start
        if (fifo_valid) begin
          state_nxt = bfg_pkg::st_wpulse;
        end
      end
      bfg_pkg::st_wpulse: begin
        if (we_cnt_r == `BFG_WE_CYCLES) begin
          state_nxt = bfg_pkg::st_wgap;
        end
      end
      bfg_pkg::st_wgap: begin
        if (!cpu_in.burst_last_n) begin
          state_nxt = bfg_pkg::st_idle;
        end else if (!profile_sel_in) begin
          state_nxt = bfg_pkg::st_whold;
        end else if (fifo_valid) begin
          cnt_inc = 1'b1;
          state_nxt = bfg_pkg::st_wpulse;
        end
      end
      bfg_pkg::st_whold: begin
        if (!cpu_in.burst_last_n) begin
          state_nxt = bfg_pkg::st_idle;
        end
      end
      bfg_pkg::st_rwait: begin
        if (wait_r <= 3'h1) begin
          state_nxt = bfg_pkg::st_rbeat;
        end else begin
          wait_nxt = wait_r - 3'h1;
        end
      end
      bfg_pkg::st_rbeat: begin
        // Each beat advances the counter to the next burst address
        cnt_inc = 1'b1;
        if (!cpu_in.burst_last_n) begin
          state_nxt = bfg_pkg::st_idle;
        end else if (next_waits != 3'h0) begin
          wait_nxt = next_waits;
          state_nxt = bfg_pkg::st_rwait;
        end
      end
      default: begin
        state_nxt = bfg_pkg::st_idle;
      end
    endcase
  end

  // Sequencer state; reset forces idle
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= bfg_pkg::st_idle;
      wait_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
      wait_r <= wait_nxt;
    end
  end

  // Strobe width counter, counts rising edges spent in the pulse state
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      we_cnt_r <= 2'h0;
    end else if (state_nxt == bfg_pkg::st_wpulse) begin
      we_cnt_r <= (state_r == bfg_pkg::st_wpulse) ? we_cnt_r + 2'h1 : 2'h1;
    end else begin
      we_cnt_r <= 2'h0;
    end
  end

  // Write strobe launched on the falling edge so the counter and select,
  // settled at the rising edge, meet address setup
  always_ff @(negedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flash_we_n_out <= 1'b1;
    end else begin
      flash_we_n_out <= state_r != bfg_pkg::st_wpulse;
    end
  end

  // Write data held for the whole strobe and past its rising edge
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      flash_wdata_out <= 32'h0;
    end else if (fifo_pop) begin
      flash_wdata_out <= fifo_data;
    end
  end

  // Chip select: set by a flash hit, kept until last with no new strobe and
  // the sequencer heading for idle, so it covers the final strobe's rising
  // edge and the final read beat even when last is raised early;
  // a new hit wins over the release so pipelined cycles keep it
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl_out.ce_n <= 1'b1;
    end else if (start) begin
      ctl_out.ce_n <= 1'b0;
    end else if (!cpu_in.burst_last_n && cpu_in.addr_strobe_n && state_nxt == bfg_pkg::st_idle) begin
      ctl_out.ce_n <= 1'b1;
    end
  end

  // Power-down follows reset; released on the first edge after it
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl_out.flash_powerdown_n <= 1'b0;
    end else begin
      ctl_out.flash_powerdown_n <= 1'b1;
    end
  end

  // Address path: idle lets the processor drive the flash directly, and
  // the counter takes the low bits once a read or write is under way
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl_out.addr_hold_strobe <= 1'b1;
      ctl_out.addr_path_select <= 1'b1;
    end else begin
      ctl_out.addr_hold_strobe <= state_nxt == bfg_pkg::st_idle;
      ctl_out.addr_path_select <= state_nxt == bfg_pkg::st_idle;
    end
  end

  // Read enables, address valid and ready to the processor
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl_out.oe_n <= 1'b1;
      ctl_out.addr_valid_n <= 1'b0;
      ctl_out.wait_release_n <= 1'b1;
    end else begin
      ctl_out.oe_n <= !(state_nxt == bfg_pkg::st_rwait || state_nxt == bfg_pkg::st_rbeat);
      // Valid while idle so the first address lands with no extra cycle
      ctl_out.addr_valid_n <= !(state_nxt == bfg_pkg::st_idle || state_nxt == bfg_pkg::st_rbeat);
      ctl_out.wait_release_n <= state_nxt != bfg_pkg::st_rbeat;
    end
  end

  // Checks

  sequence s_wr_start;
    state_r == bfg_pkg::st_idle && start && cpu_in.wr;
  endsequence

  sequence s_rd_start;
    state_r == bfg_pkg::st_idle && start && !cpu_in.wr;
  endsequence

  property p_cnt_load;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_wr_start |=> burst_count_out == $past(cpu_in.addr[3:2]);
  endproperty
  a_cnt_load: assert property (p_cnt_load) else $error("counter not loaded at write start");

  property p_we_launch;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_wr_start ##1 fifo_valid |=> !flash_we_n_out;
  endproperty
  a_we_launch: assert property (p_we_launch) else $error("write strobe not launched");

  property p_we_width;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    $fell(flash_we_n_out) |-> !flash_we_n_out [*2] ##1 flash_we_n_out;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

  property p_hold_exit;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    state_r == bfg_pkg::st_whold && !cpu_in.burst_last_n |=> state_r == bfg_pkg::st_idle;
  endproperty
  a_hold_exit: assert property (p_hold_exit) else $error("hold state did not return idle");

  property p_single_only;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    state_r == bfg_pkg::st_wgap && !profile_sel_in |=> state_r != bfg_pkg::st_wpulse;
  endproperty
  a_single_only: assert property (p_single_only) else $error("burst write in boot profile");

  property p_burst_next;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    state_r == bfg_pkg::st_wgap && profile_sel_in && cpu_in.burst_last_n && fifo_valid
      |=> state_r == bfg_pkg::st_wpulse && burst_count_out == $past(burst_count_out) + 2'h1;
  endproperty
  a_burst_next: assert property (p_burst_next) else $error("burst write did not advance");

  property p_rd_boot;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_rd_start and !profile_sel_in |=> ctl_out.wait_release_n [*4] ##1 !ctl_out.wait_release_n;
  endproperty
  a_rd_boot: assert property (p_rd_boot) else $error("boot read wait count wrong");

  property p_rd_opt;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    s_rd_start and profile_sel_in |=> ctl_out.wait_release_n [*2] ##1 !ctl_out.wait_release_n;
  endproperty
  a_rd_opt: assert property (p_rd_opt) else $error("optimised read wait count wrong");

  property p_ce_hold;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !ctl_out.ce_n && cpu_in.burst_last_n |=> !ctl_out.ce_n;
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("chip select dropped early");

  property p_miss_ignored;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    state_r == bfg_pkg::st_idle && !cpu_in.addr_strobe_n && !hit |=> state_r == bfg_pkg::st_idle;
  endproperty
  a_miss_ignored: assert property (p_miss_ignored) else $error("outside access started a cycle");

  property p_path_first;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    start && state_r == bfg_pkg::st_idle |-> ctl_out.addr_path_select ##1 !ctl_out.addr_path_select;
  endproperty
  a_path_first: assert property (p_path_first) else $error("address path not switched");

  property p_ce_over_we;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !flash_we_n_out |=> !ctl_out.ce_n;
  endproperty
  a_ce_over_we: assert property (p_ce_over_we) else $error("chip select released under write strobe");

  property p_cnt_steady;
    @(posedge clk_sys_in) disable iff (!arst_n_in)
    !flash_we_n_out |=> $stable(burst_count_out);
  endproperty
  a_cnt_steady: assert property (p_cnt_steady) else $error("burst count moved under write strobe");

endmodule
`default_nettype wire

// *** bfg_defs.svh ***
// Constants for the burst flash bus glue: address decode and timing counts.
// Assumes a 32-bit processor address and a 4 Mbyte flash window.
`ifndef BFG_DEFS_SVH
`define BFG_DEFS_SVH
// Flash space decode: address bits above the window compared to a base tag
`define BFG_TAG_LSB 22
`define BFG_TAG_W 10
`define BFG_FLASH_TAG 10'h3ff
// Low word-address bits loaded into the burst counter
`define BFG_CNT_LSB 2
`define BFG_CNT_W 2
// Write strobe width in clock periods
`define BFG_WE_CYCLES 2'h2
// Read wait states before and after configuration (first beat, next beats)
`define BFG_RD_FIRST_BOOT 3'h4
`define BFG_RD_NEXT_BOOT 3'h1
`define BFG_RD_FIRST_OPT 3'h2
`define BFG_RD_NEXT_OPT 3'h0
// Write data FIFO shape
`define BFG_FIFO_W 32
`define BFG_FIFO_D 16
`endif

// *** bfg_pkg.sv ***
// Types shared by the burst flash bus glue modules.
// Assumes bfg_defs.svh is on the include path.
`include "bfg_defs.svh"
package bfg_pkg;
  // Processor bus inputs sampled on the rising clock edge
  typedef struct packed {
    logic [31:0] addr;
    logic addr_strobe_n;
    logic wr;
    logic burst_last_n;
  } bfg_cpu_t;
  // Flash and processor control outputs, all registered
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic addr_valid_n;
    logic addr_hold_strobe;
    logic addr_path_select;
    logic wait_release_n;
    logic flash_powerdown_n;
  } bfg_ctl_t;
  // Transaction sequencer states
  typedef enum logic [2:0] {
    st_idle, st_wload, st_wpulse, st_wgap, st_whold, st_rwait, st_rbeat
  } bfg_state_t;
endpackage

// *** bfg_counter.sv ***
// Two-bit burst address counter with load and increment.
// Assumes load and increment are never requested together.
`timescale 1ns/1ns
`default_nettype none
module bfg_counter (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Control
  input wire logic load_in,
  input wire logic inc_in,
  input wire logic [1:0] load_val_in,
  // Count
  output logic [1:0] count_out
);
  // Load takes priority; wraps modulo four like the flash burst order
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      count_out <= 2'h0;
    end else if (load_in) begin
      count_out <= load_val_in;
    end else if (inc_in) begin
      count_out <= count_out + 2'h1;
    end
  end
endmodule
`default_nettype wire

// *** bfg_fifo.sv ***
// Write data FIFO between the processor data bus and the flash data pins.
// Assumes DEPTH is a power of two; flags are registered.
`timescale 1ns/1ns
`default_nettype none
module bfg_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic arst_n_in,
  // Filling side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // Draining side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_r;
  logic [AW-1:0] rptr_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;

  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;
  assign out_data_out = mem[rptr_r];

  // Occupancy after this cycle's push and pop
  always_comb begin
    cnt_nxt = cnt_r;
    if (push && !pop) begin
      cnt_nxt = cnt_r + 1'b1;
    end else if (pop && !push) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Storage has no reset; only pointers and flags need one
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem[wptr_r] <= in_data_in;
    end
  end

  // Pointers, count and flags; full and empty come from flops
  always_ff @(posedge clk_sys_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
      in_ready_out <= 1'b0;
      out_valid_out <= 1'b0;
    end else begin
      wptr_r <= push ? wptr_r + 1'b1 : wptr_r;
      rptr_r <= pop ? rptr_r + 1'b1 : rptr_r;
      cnt_r <= cnt_nxt;
      in_ready_out <= cnt_nxt != DEPTH[AW:0];
      out_valid_out <= cnt_nxt != '0;
    end
  end
endmodule
`default_nettype wire

// *** bfg_flash_model.sv ***
// Behavioural flash at the far side of the glue: records every write strobe.
// Assumes strobes are active low and the testbench drains the record queues.
`timescale 1ns/1ns
`default_nettype none
module bfg_flash_model (
  // Clock
  input wire logic clk_sys_in,
  // Flash pins seen from the glue
  input wire bfg_pkg::bfg_ctl_t ctl_in,
  input wire logic we_n_in,
  input wire logic [1:0] addr_low_in,
  input wire logic [31:0] data_in
);
  logic [1:0] cnt_q[$];
  logic [31:0] dat_q[$];
  int wid_q[$];
  bit ok_q[$];
  logic [1:0] cnt_at_fall;
  logic [31:0] dat_at_fall;
  int width;
  bit ok;
  bit armed = 0;
  int addr_takes = 0;
  // Select and address must already be settled when the strobe falls
  always @(negedge we_n_in) begin
    if (we_n_in === 1'b0) begin
      cnt_at_fall = addr_low_in;
      dat_at_fall = data_in;
      ok = (ctl_in.ce_n === 1'b0) && (ctl_in.flash_powerdown_n === 1'b1);
      width = 0;
      armed = 1;
    end
  end
  // Strobe width in whole clock periods; address taken while valid is low
  always @(posedge clk_sys_in) begin
    if (we_n_in === 1'b0) width++;
    if (ctl_in.addr_valid_n === 1'b0 && ctl_in.ce_n === 1'b0) addr_takes++;
  end
  // Data taken on the rising strobe; a reset glitch from unknown is not a write
  always @(posedge we_n_in) begin
    if (armed) begin
      cnt_q.push_back(addr_low_in);
      dat_q.push_back(data_in);
      wid_q.push_back(width);
      ok_q.push_back(ok && addr_low_in === cnt_at_fall && data_in === dat_at_fall && ctl_in.ce_n === 1'b0);
      armed = 0;
    end
  end
endmodule
`default_nettype wire

// *** burst_flash_bus_glue_tb.sv ***
// Self-checking bench: drives the processor side, compares flash writes and read beats.
// Assumes bfg_top, bfg_fifo, bfg_counter and bfg_flash_model are compiled first.
`timescale 1ns/1ns
`default_nettype none
`include "bfg_defs.svh"
module burst_flash_bus_glue_tb;
  logic clk_sys_in;
  logic arst_n_in;
  bfg_pkg::bfg_cpu_t cpu;
  logic profile_sel;
  logic wdata_valid;
  logic [31:0] wdata;
  logic wdata_ready;
  bfg_pkg::bfg_ctl_t ctl;
  logic flash_we_n;
  logic [1:0] burst_count;
  logic [31:0] flash_wdata;
  int miscompares = 0;
  int samples_checked = 0;
  int seed = 32'h139c;
  logic [31:0] ref_q[$];
  int i;
  int n;

  bfg_top bfg_top_i (.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in), .cpu_in(cpu),
    .profile_sel_in(profile_sel), .wdata_valid_in(wdata_valid), .wdata_in(wdata),
    .wdata_ready_out(wdata_ready), .ctl_out(ctl), .flash_we_n_out(flash_we_n),
    .burst_count_out(burst_count), .flash_wdata_out(flash_wdata));
  bfg_flash_model bfg_flash_model_i (.clk_sys_in(clk_sys_in), .ctl_in(ctl), .we_n_in(flash_we_n),
    .addr_low_in(burst_count), .data_in(flash_wdata));

  // Free-running 250 MHz clock
  initial begin
    clk_sys_in = 1'b0;
    forever #2 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One FIFO word, held until the ready handshake
  task automatic push_word(input logic [31:0] d);
    @(posedge clk_sys_in);
    wdata_valid <= 1'b1;
    wdata <= d;
    do @(posedge clk_sys_in); while (wdata_ready !== 1'b1);
    ref_q.push_back(d);
    wdata_valid <= 1'b0;
  endtask

  // Processor write of nw words from word address a; extra stretches the hold state
  task automatic write_txn(input logic [1:0] a, input int nw, input int extra);
    int t;
    int k;
    logic prev;
    @(posedge clk_sys_in);
    cpu <= '{addr: {`BFG_FLASH_TAG, 18'($random(seed)), a, 2'h0}, addr_strobe_n: 1'b0, wr: 1'b1,
             burst_last_n: 1'b1};
    @(posedge clk_sys_in);
    cpu.addr_strobe_n <= 1'b1;
    t = 0;
    k = 0;
    prev = 1'b1;
    while (t < 120 && !(k == nw && cpu.burst_last_n === 1'b0 && ctl.ce_n === 1'b1)) begin
      @(posedge clk_sys_in);
      t++;
      if (t == 1) begin
        chk("count_load", burst_count, a);
        chk("ce_on_write", ctl.ce_n, 1'b0);
        chk("hold_strobe_closed", ctl.addr_hold_strobe, 1'b0);
      end
      if (flash_we_n === 1'b0 && prev === 1'b1) begin
        chk("we_fall_cycle", t, 2 + 3 * k);
        k++;
      end
      prev = flash_we_n;
      if (k == nw && t >= 2 + 3 * (nw - 1) + extra && cpu.burst_last_n === 1'b1) begin
        cpu.burst_last_n <= 1'b0;
      end
      if (k < nw) chk("ce_held", ctl.ce_n, 1'b0);
    end
    chk("write_done", ctl.ce_n, 1'b1);
    cpu.burst_last_n <= 1'b1;
    chk("strobes", bfg_flash_model_i.cnt_q.size(), nw);
    for (k = 0; k < nw && bfg_flash_model_i.cnt_q.size() > 0; k++) begin
      chk("write_addr", bfg_flash_model_i.cnt_q.pop_front(), 2'(a + k));
      chk("write_data", bfg_flash_model_i.dat_q.pop_front(), ref_q.pop_front());
      chk("we_width", bfg_flash_model_i.wid_q.pop_front(), `BFG_WE_CYCLES);
      chk("settled", bfg_flash_model_i.ok_q.pop_front(), 1'b1);
    end
  endtask

  // Processor read of nb beats; beat timing follows the profile in force
  task automatic read_txn(input logic [1:0] a, input int nb);
    int t;
    int b;
    int first;
    int gap;
    int takes;
    first = profile_sel ? 3 : 5;
    gap = profile_sel ? 1 : 2;
    @(posedge clk_sys_in);
    chk("path_idle", ctl.addr_path_select, 1'b1);
    takes = bfg_flash_model_i.addr_takes;
    cpu <= '{addr: {`BFG_FLASH_TAG, 18'($random(seed)), a, 2'h0}, addr_strobe_n: 1'b0, wr: 1'b0,
             burst_last_n: 1'b1};
    @(posedge clk_sys_in);
    cpu.addr_strobe_n <= 1'b1;
    if (nb == 1) cpu.burst_last_n <= 1'b0;
    t = 0;
    b = 0;
    while (b < nb && t < 60) begin
      @(posedge clk_sys_in);
      t++;
      if (t == 1) begin
        chk("read_count", burst_count, 2'(a + 1));
        chk("path_counter", ctl.addr_path_select, 1'b0);
        chk("oe_on", ctl.oe_n, 1'b0);
      end
      if (ctl.wait_release_n === 1'b0) begin
        chk("beat_cycle", t, first + b * gap);
        chk("valid_on_beat", ctl.addr_valid_n, 1'b0);
        b++;
        if (b == nb - 1) cpu.burst_last_n <= 1'b0;
      end
    end
    chk("beats", b, nb);
    repeat (3) @(posedge clk_sys_in);
    cpu.burst_last_n <= 1'b1;
    chk("oe_off", ctl.oe_n, 1'b1);
    chk("addr_takes", bfg_flash_model_i.addr_takes - takes, nb);
  endtask

  // Watchdog: the whole sequence needs well under a few thousand cycles
  initial begin
    #(40000 * 4);
    miscompares++;
    complete_run();
  end

  // Main sequence
  initial begin
    arst_n_in = 1'b0;
    cpu = '{addr: 32'h0, addr_strobe_n: 1'b1, wr: 1'b0, burst_last_n: 1'b1};
    profile_sel = 1'b0;
    wdata_valid = 1'b0;
    wdata = 32'h0;
    repeat (8) @(posedge clk_sys_in);
    chk("rst_ce", ctl.ce_n, 1'b1);
    chk("rst_we", flash_we_n, 1'b1);
    chk("rst_count", burst_count, 2'h0);
    chk("rst_powerdown", ctl.flash_powerdown_n, 1'b0);
    arst_n_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    chk("powerdown_released", ctl.flash_powerdown_n, 1'b1);
    // Access outside the flash window must leave every strobe idle
    cpu <= '{addr: {10'h155, 22'($random(seed))}, addr_strobe_n: 1'b0, wr: 1'b1, burst_last_n: 1'b0};
    @(posedge clk_sys_in);
    cpu.addr_strobe_n <= 1'b1;
    repeat (10) begin
      @(posedge clk_sys_in);
      chk("foreign_ce", ctl.ce_n, 1'b1);
      chk("foreign_we", flash_we_n, 1'b1);
    end
    cpu.burst_last_n <= 1'b1;
    // Boot profile: slow burst read, then single writes with words left queued
    read_txn(2'($random(seed)), 4);
    for (i = 0; i < 3; i++) push_word($random(seed));
    write_txn(2'($random(seed)), 1, 4);
    write_txn(2'h3, 1, 0);
    write_txn(2'h1, 1, 2);
    // Fill the FIFO until it refuses, then drain it with one long burst
    @(posedge clk_sys_in);
    for (i = 0; i < 20; i++) begin
      wdata_valid <= 1'b1;
      wdata <= $random(seed);
      @(posedge clk_sys_in);
      if (wdata_ready === 1'b1) ref_q.push_back(wdata);
    end
    wdata_valid <= 1'b0;
    chk("fifo_depth", ref_q.size(), `BFG_FIFO_D);
    chk("fifo_full", wdata_ready, 1'b0);
    // Latency setting of two is taken as done before the profile goes high
    profile_sel <= 1'b1;
    write_txn(2'($random(seed)), `BFG_FIFO_D, 0);
    chk("fifo_space", wdata_ready, 1'b1);
    read_txn(2'($random(seed)), 4);
    read_txn(2'h3, 1);
    for (n = 0; n < 5; n++) begin
      i = 1 + ($random(seed) & 3);
      repeat (i) push_word($random(seed));
      write_txn(2'($random(seed)), i, 0);
    end
    repeat (4) @(posedge clk_sys_in);
    complete_run();
  end
endmodule
`default_nettype wire
